// *** eq_adapt_consts.svh ***
/*
 * Constants of the per-channel equalizer adaption control: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef EQ_ADAPT_CONSTS_SVH
`define EQ_ADAPT_CONSTS_SVH

`define CLK_FREQ_HZ 125000000
// lock-time bounds in ms
`define LOCK_MS_MONITOR_OFF 2
`define LOCK_MS_MONITOR_ON 12
`define LOCK_MS_FULL_ADAPT 74
`define CYCLES_PER_MS (`CLK_FREQ_HZ / 1000)

// channel register offsets (8-bit address space, 4 channels at 0x100 strides)
`define REG_SIGDET_CTRL 8'h14
`define REG_LIN_EQ_CTRL 8'h31
`define REG_FB_EQ_CTRL 8'h32
`define REG_FB_TAP_BASE 8'h33
`define REG_STATUS 8'h3A
`define REG_MONITOR_CTRL 8'h3E
`define REG_EQ_TABLE_LO 8'h40
`define REG_EQ_TABLE_HI 8'h5F

// field positions
`define MONITOR_EN_BIT 7
`define SIGDET_OVR_BIT 0
`define SIGDET_FORCE_OFF_BIT 1
`define LIN_EQ_READAPT_BIT 0
`define LIN_EQ_LIMIT_BIT 1
`define LIN_EQ_MANUAL_BIT 2
`define ADAPT_SEL_LSB 4
`define FB_EQ_EN_BIT 0
`define FB_TAP_POL_BIT 7

// reset values
`define MONITOR_CTRL_RST 8'h80
`define EQ_ENTRY_RST 8'h00
`define FB_TAP_RST 8'h00

`endif

// *** eq_adapt_pkg.sv ***
/*
 * Types shared by the equalizer adaption control.
 * Assumes nothing beyond the compile order.
 */
package eq_adapt_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic [1:0] chan;
    } reg_req_t;

    typedef struct packed {
        logic sigPresent;
        logic cdrReset;
        logic cdrLocked;
        logic [7:0] figure_of_merit;
        logic fomValid;
    } chan_in_t;

    typedef struct packed {
        logic pathPowerOn;
        logic [7:0] linEqBoost;
        logic limitStage;
        logic fbEqEnable;
        logic fbEqAdaptRun;
        logic [39:0] fbTaps;
        logic monitorEnable;
        logic adaptDone;
        logic lockTimeout;
        logic vcoCalStart;
    } chan_out_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SWEEP,
        ST_WAIT_LOCK,
        ST_FROZEN
    } adapt_state_t;
endpackage : eq_adapt_pkg

// *** eq_channel.sv ***
/*
 * One channel of the equalizer adaption control: signal-detect gating,
 * linear equalizer table sweep and freeze, feedback equalizer settings,
 * eye-opening lock monitor enable and lock timeout watch.
 * Assumes register writes come from the parent's decode, one cycle each.
 */
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "eq_adapt_consts.svh"

module eq_channel #(
    parameter int TABLE_DEPTH = 32,
    parameter int TAPS = 5,
    parameter int MS_CYCLES = `CYCLES_PER_MS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register access
    input wire logic regWr,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // analog side
    input eq_adapt_pkg::chan_in_t chanIn,
    output eq_adapt_pkg::chan_out_t chanOut
);
    import eq_adapt_pkg::*;

    // table index, tap bus and the 17-bit cycle counter are sized for these values only
    if (TABLE_DEPTH != 32 || TAPS != 5 || MS_CYCLES < 1 || MS_CYCLES > 131072)
    begin : g_badParams
        $error("eq_channel: unsupported parameters");
    end

    logic [7:0] eqTable_ff [TABLE_DEPTH];
    logic [7:0] monCtrl_ff;
    logic [7:0] sigCtrl_ff;
    logic [7:0] linCtrl_ff;
    logic [7:0] fbCtrl_ff;
    logic [7:0] fbTap_ff [TAPS];
    adapt_state_t state_ff;
    logic [4:0] idx_ff;
    logic [4:0] bestIdx_ff;
    logic [7:0] bestFom_ff;
    logic [7:0] boost_ff;
    logic [16:0] cycCnt_ff;
    logic [6:0] msCnt_ff;
    logic timeout_ff;
    logic readapt;
    logic [6:0] lockLimit;
    logic calStart_ff;

    assign readapt = regWr && regAddr == `REG_LIN_EQ_CTRL && regWdata[`LIN_EQ_READAPT_BIT];

    // table entries: four 2-bit stage fields, any of 256 codes
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < TABLE_DEPTH; i++)
        begin
            if (!rst_n)
                eqTable_ff[i] <= `EQ_ENTRY_RST;
            else if (regWr && regAddr == `REG_EQ_TABLE_LO + 8'(i))
                eqTable_ff[i] <= regWdata;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            monCtrl_ff <= `MONITOR_CTRL_RST;
            sigCtrl_ff <= 8'h00;
            linCtrl_ff <= 8'h00;
            fbCtrl_ff <= 8'h00;
        end
        else if (regWr)
        begin
            if (regAddr == `REG_MONITOR_CTRL)
                monCtrl_ff <= regWdata;
            if (regAddr == `REG_SIGDET_CTRL)
                sigCtrl_ff <= regWdata;
            if (regAddr == `REG_LIN_EQ_CTRL)
                linCtrl_ff <= {regWdata[7:1], 1'b0};
            if (regAddr == `REG_FB_EQ_CTRL)
                fbCtrl_ff <= regWdata;
        end
    end

    // power-up also asks for calibration: held through reset, dropped one cycle after
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            calStart_ff <= 1'b1;
        else
            calStart_ff <= 1'b0;
    end

    // manual tap polarity and weight, one word per tap
    always_ff @(posedge mclk)
    begin
        for (int t = 0; t < TAPS; t++)
        begin
            if (!rst_n)
                fbTap_ff[t] <= `FB_TAP_RST;
            else if (regWr && regAddr == `REG_FB_TAP_BASE + 8'(t))
                fbTap_ff[t] <= regWdata;
        end
    end

    // sweep the table comparing figure_of_merit, then freeze
    always_ff @(posedge mclk)
    begin
        if (!rst_n || chanIn.cdrReset)
        begin
            state_ff <= ST_IDLE;
            idx_ff <= 5'h00;
            bestIdx_ff <= 5'h00;
            bestFom_ff <= 8'h00;
            boost_ff <= 8'h00;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    // a manual setting has nothing to sweep, so lock timing starts at once
                    if (chanIn.sigPresent && linCtrl_ff[`LIN_EQ_MANUAL_BIT])
                        state_ff <= ST_WAIT_LOCK;
                    else if (chanIn.sigPresent)
                    begin
                        state_ff <= ST_SWEEP;
                        idx_ff <= 5'h00;
                        bestFom_ff <= 8'h00;
                        boost_ff <= eqTable_ff[0];
                    end
                end
                ST_SWEEP:
                begin
                    if (chanIn.fomValid)
                    begin
                        if (chanIn.figure_of_merit > bestFom_ff || idx_ff == 5'h00)
                        begin
                            bestFom_ff <= chanIn.figure_of_merit;
                            bestIdx_ff <= idx_ff;
                        end
                        if (idx_ff == 5'(TABLE_DEPTH - 1))
                        begin
                            state_ff <= ST_WAIT_LOCK;
                            boost_ff <= (chanIn.figure_of_merit > bestFom_ff) ? eqTable_ff[idx_ff]
                                                                   : eqTable_ff[bestIdx_ff];
                        end
                        else
                        begin
                            idx_ff <= idx_ff + 5'h01;
                            boost_ff <= eqTable_ff[idx_ff + 5'h01];
                        end
                    end
                end
                ST_WAIT_LOCK:
                begin
                    if (chanIn.cdrLocked)
                        state_ff <= ST_FROZEN;
                end
                ST_FROZEN:
                begin
                    // a re-adapt command, loss of lock or a recovery reset reopens the sweep
                    if (readapt || !chanIn.cdrLocked)
                        state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // lock time counted from end of linear adaption
    always_comb
    begin
        if (fbCtrl_ff[`FB_EQ_EN_BIT] && !linCtrl_ff[`LIN_EQ_MANUAL_BIT])
            lockLimit = 7'(`LOCK_MS_FULL_ADAPT);
        else if (monCtrl_ff[`MONITOR_EN_BIT])
            lockLimit = 7'(`LOCK_MS_MONITOR_ON);
        else
            lockLimit = 7'(`LOCK_MS_MONITOR_OFF);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n || state_ff != ST_WAIT_LOCK)
        begin
            cycCnt_ff <= 17'h00000;
            msCnt_ff <= 7'h00;
            timeout_ff <= 1'b0;
        end
        else if (cycCnt_ff == 17'(MS_CYCLES - 1))
        begin
            cycCnt_ff <= 17'h00000;
            msCnt_ff <= msCnt_ff + 7'h01;
            if (msCnt_ff + 7'h01 >= lockLimit)
                timeout_ff <= 1'b1;
        end
        else
            cycCnt_ff <= cycCnt_ff + 17'h00001;
    end

    always_comb
    begin
        chanOut.pathPowerOn = sigCtrl_ff[`SIGDET_OVR_BIT]
                            ? !sigCtrl_ff[`SIGDET_FORCE_OFF_BIT]
                            : chanIn.sigPresent;
        chanOut.linEqBoost = linCtrl_ff[`LIN_EQ_MANUAL_BIT] ? eqTable_ff[0] : boost_ff;
        chanOut.limitStage = linCtrl_ff[`LIN_EQ_LIMIT_BIT];
        chanOut.fbEqEnable = fbCtrl_ff[`FB_EQ_EN_BIT];
        chanOut.fbEqAdaptRun = fbCtrl_ff[`FB_EQ_EN_BIT] && (state_ff == ST_WAIT_LOCK
                             || (state_ff == ST_FROZEN
                                 && fbCtrl_ff[`ADAPT_SEL_LSB + 1]));
        for (int t = 0; t < TAPS; t++)
            chanOut.fbTaps[t*8 +: 8] = fbTap_ff[t];
        chanOut.monitorEnable = monCtrl_ff[`MONITOR_EN_BIT];
        chanOut.adaptDone = state_ff == ST_WAIT_LOCK || state_ff == ST_FROZEN;
        chanOut.lockTimeout = timeout_ff;
        chanOut.vcoCalStart = chanIn.cdrReset || calStart_ff;
    end

    always_comb
    begin
        regRdata = 8'h00;
        if (regAddr >= `REG_EQ_TABLE_LO && regAddr <= `REG_EQ_TABLE_HI)
            regRdata = eqTable_ff[regAddr[4:0]];
        else if (regAddr >= `REG_FB_TAP_BASE && regAddr < `REG_FB_TAP_BASE + 8'(TAPS))
            regRdata = fbTap_ff[3'(regAddr - `REG_FB_TAP_BASE)];
        else
        begin
            unique case (regAddr)
                `REG_MONITOR_CTRL: regRdata = monCtrl_ff;
                `REG_SIGDET_CTRL: regRdata = sigCtrl_ff;
                `REG_LIN_EQ_CTRL: regRdata = linCtrl_ff;
                `REG_FB_EQ_CTRL: regRdata = fbCtrl_ff;
                `REG_STATUS: regRdata = {4'h0, timeout_ff, chanIn.cdrLocked,
                                         state_ff == ST_FROZEN, chanIn.sigPresent};
                default: regRdata = 8'h00;
            endcase
        end
    end
endmodule : eq_channel

// *** eq_adapt_ctrl.sv ***
/*
 * Top of the equalizer adaption control: four independent channels behind
 * one register port that stands in for the serial management bus.
 * Assumes one clock, synchronous active-low reset, and analog inputs already
 * synchronous to mclk.
 */
`timescale 1ns/1ps
`include "eq_adapt_consts.svh"

module eq_adapt_ctrl #(
    parameter int CHANNELS = 4,
    parameter int MS_CYCLES = `CYCLES_PER_MS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [9:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // per-channel analog side
    input eq_adapt_pkg::chan_in_t chanIn [4],
    output eq_adapt_pkg::chan_out_t chanOut [4]
);
    import eq_adapt_pkg::*;

    if (CHANNELS != 4)
    begin : g_badParams
        $error("eq_adapt_ctrl: four channels only");
    end

    logic [7:0] chanRdata [4];
    logic [7:0] rdata_ff;

    // each channel has private settings and state
    for (genvar c = 0; c < 4; c++)
    begin : g_chan
        eq_channel #(
            .TABLE_DEPTH(32),
            .TAPS(5),
            .MS_CYCLES(MS_CYCLES)
        ) u_chan (
            .mclk(mclk),
            .rst_n(rst_n),
            .regWr(regWr && regAddr[9:8] == 2'(c)),
            .regAddr(regAddr[7:0]),
            .regWdata(regWdata),
            .regRdata(chanRdata[c]),
            .chanIn(chanIn[c]),
            .chanOut(chanOut[c])
        );
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !regRd)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= chanRdata[regAddr[9:8]];
    end

    assign regRdata = rdata_ff;
endmodule : eq_adapt_ctrl

// *** eq_adapt_props.sv ***
/*
 * Concurrent checks on the ports of the equalizer adaption control.
 * Assumes one clock, synchronous active-low reset; watches channel 0, and
 * channel 1 for lock timing.
 */
`timescale 1ns/1ps
module eq_adapt_props #(
    parameter int MS_CYCLES = 10
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [9:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    // channel side
    input eq_adapt_pkg::chan_in_t chanIn [4],
    input eq_adapt_pkg::chan_out_t chanOut [4]
);
    import eq_adapt_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic detOvr_ff;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            detOvr_ff <= 1'b0;
        else if (regWr && regAddr == 10'h014)
            detOvr_ff <= regWdata[0];
    end
    // cycles since channel 1 finished adaption, against the shortest lock limit
    int doneCyc_ff;
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !chanOut[1].adaptDone)
            doneCyc_ff <= 0;
        else
            doneCyc_ff <= doneCyc_ff + 1;
    end
    sequence s_monWr;
        regWr && regAddr == 10'h03E;
    endsequence
    sequence s_held;
        chanOut[0].adaptDone [*2];
    endsequence
    property p_monWr;
        s_monWr |=> chanOut[0].monitorEnable == $past(regWdata[7]);
    endproperty
    a_monWr: assert property (p_monWr)
        else $error("monitor enable does not follow write");
    // reset itself is the cause here, so it must not disable the check
    property p_monRst;
        disable iff (1'b0) !rst_n |=> chanOut[0].monitorEnable;
    endproperty
    a_monRst: assert property (p_monRst)
        else $error("monitor enable not set by reset");
    property p_rdIdle;
        !$past(regRd) |-> regRdata == 8'h00;
    endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data outside read cycle");
    property p_chanIso;
        regWr && regAddr[9:8] != 2'h0 |=> $stable(chanOut[0].monitorEnable)
            && $stable(chanOut[0].fbEqEnable);
    endproperty
    a_chanIso: assert property (p_chanIso)
        else $error("other channel write changed channel 0");
    property p_fbEn;
        $rose(chanOut[0].fbEqEnable) |-> $past(regWr && regAddr == 10'h032 && regWdata[0]);
    endproperty
    a_fbEn: assert property (p_fbEn)
        else $error("feedback equalizer enabled without write");
    property p_limit;
        $rose(chanOut[0].limitStage) |-> $past(regWr && regAddr == 10'h031 && regWdata[1]);
    endproperty
    a_limit: assert property (p_limit)
        else $error("limiting stage set without write");
    property p_frozen;
        (s_held ##0 !$past(regWr)) |-> $stable(chanOut[0].linEqBoost);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("boost moved while adaption done");
    property p_vco;
        chanOut[0].vcoCalStart == (chanIn[0].cdrReset || !$past(rst_n));
    endproperty
    a_vco: assert property (p_vco)
        else $error("recovery reset did not start calibration");
    property p_pathOn;
        !detOvr_ff && $stable(chanIn[0].sigPresent)
            |-> chanOut[0].pathPowerOn == chanIn[0].sigPresent;
    endproperty
    a_pathOn: assert property (p_pathOn)
        else $error("path power does not follow detector");
    property p_toEarly;
        $rose(chanOut[1].lockTimeout) |-> doneCyc_ff >= 2 * MS_CYCLES;
    endproperty
    a_toEarly: assert property (p_toEarly)
        else $error("lock timeout before shortest limit");
endmodule : eq_adapt_props

bind eq_adapt_ctrl eq_adapt_props #(.MS_CYCLES(MS_CYCLES)) u_props (.mclk(mclk),
    .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .chanIn(chanIn), .chanOut(chanOut));

// *** eq_far_side.sv ***
/*
 * Upstream transmitter and lossy line seen by the four channels.
 * Assumes the bench steers energy, recovery reset and lock success per channel.
 */
`timescale 1ns/1ps
module eq_far_side #(
    parameter int LOCK_DLY = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bench control
    input wire logic [3:0] energy,
    input wire logic [3:0] rstCdr,
    input wire logic [3:0] lockOk,
    input wire logic [7:0] fomTbl [32],
    // channel side of the retimer
    output eq_adapt_pkg::chan_in_t chanIn [4]
);
    import eq_adapt_pkg::*;
    for (genvar c = 0; c < 4; c++)
    begin : g_ch
        logic [5:0] idx_ff;
        logic [1:0] gap_ff;
        logic [7:0] wait_ff;
        logic [7:0] fom_ff;
        logic fomVld_ff;
        logic lock_ff;
        always_ff @(posedge mclk)
        begin
            fomVld_ff <= 1'b0;
            // figure lines never hold a stale value outside the pulse
            fom_ff <= ~fom_ff;
            if (!rst_n || rstCdr[c] || !energy[c])
            begin
                idx_ff <= 6'h00;
                gap_ff <= 2'h0;
                wait_ff <= 8'h00;
                lock_ff <= 1'b0;
                fom_ff <= 8'h00;
            end
            else if (idx_ff < 6'h20)
            begin
                gap_ff <= gap_ff + 2'h1;
                if (gap_ff == 2'h3)
                begin
                    fomVld_ff <= 1'b1;
                    fom_ff <= fomTbl[idx_ff[4:0]];
                    idx_ff <= idx_ff + 6'h01;
                end
            end
            else if (wait_ff < 8'(LOCK_DLY))
                wait_ff <= wait_ff + 8'h01;
            else
                lock_ff <= lockOk[c];
        end
        assign chanIn[c] = '{sigPresent: energy[c], cdrReset: rstCdr[c], cdrLocked: lock_ff,
            figure_of_merit: fom_ff, fomValid: fomVld_ff};
    end
endmodule : eq_far_side

// *** tb.sv ***
/*
 * Self-checking bench for the equalizer adaption control.
 * Assumes the far-side model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
module tb;
    import eq_adapt_pkg::*;
    localparam int MS = 10;
    logic mclk;
    logic rst_n;
    logic regWr;
    logic regRd;
    logic [9:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    chan_in_t chanIn [4];
    chan_out_t chanOut [4];
    logic [3:0] energy;
    logic [3:0] rstCdr;
    logic [3:0] lockOk;
    logic [7:0] fomTbl [32];
    logic [7:0] tbl [32];
    logic [39:0] taps;
    int num_errors;
    int checks_done;
    int cyc = 0;
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    eq_adapt_ctrl #(.CHANNELS(4), .MS_CYCLES(MS)) u_dut (.mclk(mclk), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .chanIn(chanIn), .chanOut(chanOut));
    eq_far_side #(.LOCK_DLY(8)) u_far (.mclk(mclk), .rst_n(rst_n), .energy(energy),
        .rstCdr(rstCdr), .lockOk(lockOk), .fomTbl(fomTbl), .chanIn(chanIn));
    task automatic conclude();
        $display("errors %0d, checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rdChk(input logic [9:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        @(posedge mclk);
        chk(40'(regRdata), 40'(exp));
    endtask : rdChk
    // stalls are bounded so a dead sweep ends as a mismatch, not a hang
    task automatic waitDone(input int c);
        int n;
        n = 0;
        while (chanOut[c].adaptDone !== 1'b1 && n < 500)
        begin
            @(posedge mclk);
            n++;
        end
        chk(40'(n < 500), 40'h1);
    endtask : waitDone
    function automatic int best();
        int b;
        b = 0;
        for (int i = 1; i < 32; i++)
            if (fomTbl[i] > fomTbl[b])
                b = i;
        return b;
    endfunction : best
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            conclude();
        end
    end
    initial
    begin
        int n;
        int lim;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 10'h000;
        regWdata = 8'h00;
        energy = 4'h0;
        rstCdr = 4'h0;
        lockOk = 4'hF;
        rst_n = 1'b0;
        num_errors = 0;
        checks_done = 0;
        void'($urandom(32'h61CE));
        foreach (fomTbl[i])
            fomTbl[i] = 8'($urandom);
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        chk(40'(chanOut[0].vcoCalStart), 40'h1);
        for (int c = 0; c < 4; c++)
            rdChk({2'(c), 8'h3E}, 8'h80);
        rdChk(10'h0FF, 8'h00);
        wr(10'h03E, 8'h00);
        rdChk(10'h03E, 8'h00);
        wr(10'h03E, 8'h80);
        foreach (tbl[i])
            tbl[i] = (i == 31) ? 8'hFF : 8'($urandom);
        foreach (tbl[i])
            wr(10'h040 + 10'(i), tbl[i]);
        foreach (tbl[i])
            rdChk(10'h040 + 10'(i), tbl[i]);
        energy[0] <= 1'b1;
        waitDone(0);
        chk(40'(chanOut[0].linEqBoost), 40'(tbl[best()]));
        repeat (20) @(posedge mclk);
        chk(40'(chanOut[0].linEqBoost), 40'(tbl[best()]));
        rdChk(10'h03A, 8'h07);
        for (int m = 0; m < 8; m++)
        begin
            wr(10'h032, {2'h0, 2'(m >> 1), 3'h0, 1'(m)});
            @(posedge mclk);
            chk(40'(chanOut[0].fbEqEnable), 40'(m & 1));
            if (m & 1)
                chk(40'(chanOut[0].fbEqAdaptRun), 40'(m >= 4));
        end
        wr(10'h032, 8'h00);
        for (int t = 0; t < 5; t++)
        begin
            taps[8 * t +: 8] = 8'($urandom);
            wr(10'h033 + 10'(t), taps[8 * t +: 8]);
        end
        @(posedge mclk);
        chk(chanOut[0].fbTaps, taps);
        wr(10'h031, 8'h02);
        @(posedge mclk);
        chk(40'(chanOut[0].limitStage), 40'h1);
        wr(10'h031, 8'h03);
        repeat (2) @(posedge mclk);
        chk(40'(chanOut[0].adaptDone), 40'h0);
        rdChk(10'h031, 8'h02);
        wr(10'h031, 8'h00);
        foreach (fomTbl[i])
            fomTbl[i] = 8'($urandom);
        rstCdr[0] <= 1'b1;
        @(posedge mclk);
        rstCdr[0] <= 1'b0;
        chk(40'(chanOut[0].vcoCalStart), 40'h1);
        waitDone(0);
        chk(40'(chanOut[0].linEqBoost), 40'(tbl[best()]));
        wr(10'h014, 8'h03);
        @(posedge mclk);
        chk(40'(chanOut[0].pathPowerOn), 40'h0);
        wr(10'h014, 8'h00);
        @(posedge mclk);
        chk(40'(chanOut[0].pathPowerOn), 40'h1);
        lockOk[3:1] <= 3'h0;
        wr(10'h131, 8'h04);
        wr(10'h231, 8'h04);
        wr(10'h13E, 8'h00);
        wr(10'h332, 8'h21);
        for (int c = 1; c < 4; c++)
        begin
            lim = (c == 1) ? 2 * MS : (c == 2) ? 12 * MS : 74 * MS;
            energy[c] <= 1'b1;
            waitDone(c);
            n = 0;
            while (chanOut[c].lockTimeout !== 1'b1 && n < 1000)
            begin
                @(posedge mclk);
                n++;
            end
            chk(40'(n >= lim - 3 && n <= lim + 3), 40'h1);
        end
        conclude();
    end
endmodule : tb
